// [src/bthc_defs.vh]
// Purpose: constants for the bus trigger and history capture block
// Assumes: one 109-bit captured word per qualified bus cycle
// Notes:   definitions only
`ifndef BTHC_DEFS_VH
`define BTHC_DEFS_VH
`define BTHC_WORD_W      109
`define BTHC_STAGE1_W    14
`define BTHC_STAGE2_W    2
`define BTHC_POST_COUNT  2'h2
`define BTHC_CHUNK_W     8
`endif

// [src/bthc_capture.v]
// Purpose: trigger compare and five-entry history capture for a bus analyzer
// Assumes: bus_word and qualify are synchronous to ref_clk
// Notes:   mask and pattern arrive as ports; no software registers here
// Operation
// - run_n low while capturing, else high
// - match_n low when history matches trigger
// - on trigger match_n low, run_n high two qualified cycles later
// - match_n stays low until reset or start
// - five history entries of 109 bits
// - trigger entry plus two preceding cycles
// - two following cycles after the trigger
// - same bit layout for setup and history
// - mask, xor, three-clock or-reduce, zero matches
// - start, stop act on falling edges
// - stop ends capture at once, freezes history
// - reset stops and clears history
`include "bthc_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module bthc_capture #(
   parameter WORD_W = `BTHC_WORD_W
) (
   input  wire              ref_clk,        // bus clock
   input  wire              rst_n,          // async reset, active low
   input  wire              clk_en,         // freezes all state while low
   input  wire [WORD_W-1:0] bus_word,       // captured bus cycle word
   input  wire              qualify,        // bus_word holds a cycle to capture
   input  wire [WORD_W-1:0] mask,           // compare mask, 1 = compare bit
   input  wire [WORD_W-1:0] pattern,        // compare pattern
   input  wire              start_n,        // start, acts on falling edge
   input  wire              stop_input,     // stop, acts on falling edge
   output reg               run_n,          // low while capturing
   output reg               match_n,        // low after a trigger
   output reg  [WORD_W-1:0] history_before_2, // two cycles before trigger
   output reg  [WORD_W-1:0] history_before_1, // cycle before trigger
   output reg  [WORD_W-1:0] history_trigger_entry, // triggering cycle
   output reg  [WORD_W-1:0] history_after_1,  // cycle after trigger
   output reg  [WORD_W-1:0] history_after_2   // two cycles after trigger
);
   localparam N1 = `BTHC_STAGE1_W;
   localparam CH = `BTHC_CHUNK_W;
   localparam ST_IDLE = 2'h0;
   localparam ST_RUN  = 2'h1;
   localparam ST_POST = 2'h2;

   // timing through the block, counted in edges of ref_clk with clk_en high:
   //   edge k    word k is sampled into cmp_reg and into the first data stage
   //   edge k+1  the first or-stage folds the compare into fourteen groups
   //   edge k+2  the second or-stage folds fourteen groups into two halves
   //   edge k+3  hit_reg holds the match of word k
   //   from k+3  d4_reg and q4_reg hold word k and its qualifier, so the
   //             trigger decision and the word that caused it meet at last
   // the data line is as deep as the compare pipe on purpose: a line one
   // stage shorter shifts the word after the trigger word into the middle
   // entry and the whole history comes out one cycle late.
   //
   // the history line always shifts towards history_before_2. the trigger
   // word enters history_after_2 at the edge that sees the match, and two
   // more qualified words move it into history_trigger_entry. only then
   // does run_n go high, so all five entries are valid once capture ends.
   //
   // limitations a user must know:
   //   a stop freezes at once and takes no post cycles, so the after
   //   entries then hold the newest words rather than a trigger's followers.
   //   a match seen while the post cycles run is ignored; the first match
   //   of a capture wins.
   //   the words still in the pipe when a start falls are discarded, which
   //   costs four cycles of history right after a start.
   //   a mask bit at zero with the same pattern bit at one can never match;
   //   such a setup simply never triggers.
   //   clk_en low freezes every stage, the edge detectors too, so a start
   //   or stop edge that comes and goes while it is low is lost.

   reg  [1:0]        state_reg;
   reg  [1:0]        post_cnt_reg;
   reg               start_d_reg;
   reg               stop_d_reg;
   reg  [WORD_W-1:0] cmp_reg;
   reg  [N1-1:0]     or1_reg;
   reg  [1:0]        or2_reg;
   reg               hit_reg;
   reg  [WORD_W-1:0] d1_reg;
   reg  [WORD_W-1:0] d2_reg;
   reg  [WORD_W-1:0] d3_reg;
   reg               q1_reg;
   reg               q2_reg;
   reg               q3_reg;
   reg  [WORD_W-1:0] d4_reg;
   reg               q4_reg;
   reg  [N1-1:0]     or1_next;
   integer           i;

   wire start_fall = start_d_reg & ~start_n;
   wire stop_fall  = stop_d_reg & ~stop_input;
   wire capturing  = (state_reg != ST_IDLE);
   // the match lags its word by four clocks, so the word rides a parallel delay line
   wire trig       = (state_reg == ST_RUN) & q4_reg & hit_reg;

   // first or-stage folds 109 bits to 14 groups of up to eight
   always @* begin
      or1_next = {N1{1'b0}};
      for (i = 0; i < WORD_W; i = i + 1)
         or1_next[i/CH] = or1_next[i/CH] | cmp_reg[i];
   end

   // compare pipeline and aligned data path
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_reg <= {WORD_W{1'b0}};
         or1_reg <= {N1{1'b0}};
         or2_reg <= 2'h0;
         hit_reg <= 1'b0;
         d1_reg  <= {WORD_W{1'b0}};
         d2_reg  <= {WORD_W{1'b0}};
         d3_reg  <= {WORD_W{1'b0}};
         q1_reg  <= 1'b0;
         q2_reg  <= 1'b0;
         q3_reg  <= 1'b0;
         d4_reg  <= {WORD_W{1'b0}};
         q4_reg  <= 1'b0;
      end else if (clk_en) begin
         cmp_reg <= (bus_word & mask) ^ pattern;
         or1_reg <= or1_next;
         or2_reg <= {|or1_reg[N1-1:N1/2], |or1_reg[N1/2-1:0]};
         hit_reg <= ~(|or2_reg);
         d1_reg  <= bus_word;
         d2_reg  <= d1_reg;
         d3_reg  <= d2_reg;
         q1_reg  <= qualify & capturing & ~start_fall;
         q2_reg  <= q1_reg & ~start_fall;
         q3_reg  <= q2_reg & ~start_fall;
         d4_reg  <= d3_reg;
         q4_reg  <= q3_reg & ~start_fall;
      end
   end

   // capture control: start wins over a simultaneous stop
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= ST_IDLE;
         post_cnt_reg <= 2'h0;
         start_d_reg  <= 1'b1;
         stop_d_reg   <= 1'b1;
         run_n        <= 1'b1;
         match_n      <= 1'b1;
      end else if (clk_en) begin
         start_d_reg <= start_n;
         stop_d_reg  <= stop_input;
         if (start_fall) begin
            state_reg <= ST_RUN;
            run_n     <= 1'b0;
            match_n   <= 1'b1;
         end else if (stop_fall && capturing) begin
            state_reg <= ST_IDLE;
            run_n     <= 1'b1;
         end else begin
            case (state_reg)
               ST_RUN: begin
                  if (trig) begin
                     state_reg    <= ST_POST;
                     post_cnt_reg <= 2'h0;
                     match_n      <= 1'b0;
                  end
               end
               ST_POST: begin
                  if (q4_reg) begin
                     post_cnt_reg <= post_cnt_reg + 2'h1;
                     if (post_cnt_reg == `BTHC_POST_COUNT - 2'h1) begin
                        state_reg <= ST_IDLE;
                        run_n     <= 1'b1;
                     end
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // five-entry shift line; only qualified cycles enter while capturing
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         history_before_2      <= {WORD_W{1'b0}};
         history_before_1      <= {WORD_W{1'b0}};
         history_trigger_entry <= {WORD_W{1'b0}};
         history_after_1       <= {WORD_W{1'b0}};
         history_after_2       <= {WORD_W{1'b0}};
      end else if (clk_en) begin
         if (start_fall) begin
            history_before_2      <= {WORD_W{1'b0}};
            history_before_1      <= {WORD_W{1'b0}};
            history_trigger_entry <= {WORD_W{1'b0}};
            history_after_1       <= {WORD_W{1'b0}};
            history_after_2       <= {WORD_W{1'b0}};
         end else if (capturing && !stop_fall && q4_reg) begin
            // oldest at before_2; after the two post shifts the trigger sits in the middle
            history_before_2      <= history_before_1;
            history_before_1      <= history_trigger_entry;
            history_trigger_entry <= history_after_1;
            history_after_1       <= history_after_2;
            history_after_2       <= d4_reg;
         end
      end
   end
endmodule
`default_nettype wire

// [verification/bthc_bus_src.sv]
// Purpose: processor bus model, one counting word per cycle
// Assumes: every bus cycle outside reset is a qualified cycle
// Notes:   word equals cycle count, so history contents are predictable
`timescale 1ns/10ps
`default_nettype none
module bthc_bus_src (
   input  wire logic         ref_clk,  // bus clock
   input  wire logic         rst_n,    // reset, active low
   output wire logic         qualify,  // word is a real cycle
   output var  logic [108:0] bus_word  // counting bus word
);
   // word moves just after the edge so the block always samples it settled
   always @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         bus_word <= '0;
      else
         bus_word <= #1 bus_word + 109'h1;
   assign qualify = rst_n;
endmodule
`default_nettype wire

// [verification/bthc_capture_properties.sv]
// Purpose: port checker for bthc_capture
// Assumes: one clock domain, async reset
// Notes:   bound to every instance
`timescale 1ns/10ps
`default_nettype none
module bthc_props #(parameter WORD_W = 109) (
   input wire logic ref_clk, rst_n, clk_en, qualify, start_n, stop_input, run_n, match_n,
   input wire logic [WORD_W-1:0] history_trigger_entry, history_after_2, history_before_2
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // start seen, and trigger followed by the two post cycles
   sequence s_start; $fell(start_n) && clk_en; endsequence
   sequence s_post2; $fell(match_n) ##0 qualify ##1 (qualify && !run_n); endsequence
   a_start_runs: assert property (s_start |=> !run_n && match_n)
      else $error("start ignored");
   a_start_clears: assert property (s_start |=> history_trigger_entry == '0)
      else $error("history not cleared");
   a_match_holds: assert property (!match_n && !$fell(start_n) |=> !match_n)
      else $error("match released");
   a_trig_running: assert property ($fell(match_n) |-> !run_n && $past(run_n) == 1'h0)
      else $error("match outside capture");
   a_post_two: assert property (s_post2 |=> run_n)
      else $error("post count wrong");
   a_reset_idle: assert property ($rose(rst_n) |-> run_n && match_n && history_before_2 == '0)
      else $error("reset state wrong");
   a_stop_halts: assert property ($fell(stop_input) && clk_en && !$fell(start_n) |=> run_n)
      else $error("stop ignored");
   a_idle_frozen: assert property (run_n && !$fell(start_n) |=> run_n && $stable(history_after_2))
      else $error("idle state moved");
endmodule
bind bthc_capture bthc_props #(.WORD_W(WORD_W)) u_props (.ref_clk, .rst_n, .clk_en, .qualify,
   .start_n, .stop_input, .run_n, .match_n, .history_trigger_entry, .history_after_2,
   .history_before_2);
`default_nettype wire

// [verification/bthc_capture_test.sv]
// Purpose: self-checking bench for bthc_capture
// Assumes: counting bus words, all bits compared
// Notes:   trigger value chosen so every history entry is known
`timescale 1ns/10ps
`default_nettype none
module bthc_capture_test;
   logic         ref_clk, rst_n, start_n, stop_input, run_n, match_n, qualify, clk_en;
   logic [108:0] bus_word, pattern, hb2, hb1, hz, ha1, ha2, kept;
   int           miscompares, checks_done, cyc;
   bthc_bus_src src (.ref_clk, .rst_n, .qualify, .bus_word);
   bthc_capture dut (.ref_clk, .rst_n, .clk_en, .bus_word, .qualify, .mask(~109'h0),
      .pattern, .start_n, .stop_input, .run_n, .match_n, .history_before_2(hb2),
      .history_before_1(hb1), .history_trigger_entry(hz), .history_after_1(ha1),
      .history_after_2(ha2));
   // clock, plus a ceiling far above the hundred or so cycles used
   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
      if (++cyc > 2000) begin
         miscompares++;
         report_and_stop();
      end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [108:0] got, input logic [108:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic pulse(input bit stop);
      if (stop) stop_input = 1'h0;
      else start_n = 1'h0;
      tick(1);
      stop_input = 1'h1;
      start_n = 1'h1;
   endtask
   task automatic t_trig();
      pattern = 109'h40;
      pulse(0);
      chk(run_n, 109'h0);
      repeat (100) if (run_n !== 1'h1) tick(1);
      chk(run_n, 109'h1);
      chk(match_n, 109'h0);
      chk(hz, 109'h40);
      chk(hb1, 109'h3F);
      chk(hb2, 109'h3E);
      chk(ha1, 109'h41);
      chk(ha2, 109'h42);
      tick(5);
      chk(match_n, 109'h0);
   endtask
   task automatic t_reset();
      rst_n = 1'h0;
      tick(2);
      chk(match_n, 109'h1);
      chk(hz, 109'h0);
      rst_n = 1'h1;
      tick(1);
   endtask
   task automatic t_stop();
      pattern = 109'h1 << 108;
      pulse(0);
      chk(hz, 109'h0);
      tick(8);
      clk_en = 1'h0;
      kept = ha2;
      tick(3);
      chk(ha2, kept);
      chk(run_n, 109'h0);
      clk_en = 1'h1;
      tick(2);
      pulse(1);
      chk(run_n, 109'h1);
      kept = ha2;
      tick(4);
      chk(ha2, kept);
      chk(match_n, 109'h1);
   endtask
   task report_and_stop();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      rst_n = 1'h0;
      clk_en = 1'h1;
      start_n = 1'h1;
      stop_input = 1'h1;
      pattern = 109'h0;
      tick(4);
      rst_n = 1'h1;
      tick(1);
      t_trig();
      t_reset();
      t_stop();
      report_and_stop();
   end
endmodule
`default_nettype wire
